/* File: rtl/borc_params.svh */
// Purpose: Timing and reset constants of the breaker output relay control
// Assumes: 250 MHz system clock, one common 10 ms tick
// Notes:   All delays are counted in ticks
`ifndef BORC_PARAMS_SVH
`define BORC_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and tick
// ----------------------------------------------------------------------
`define BORC_CLK_PERIOD_NS  4
`define BORC_TICK_MS        10
`define BORC_TICK_NS        (`BORC_TICK_MS * 1000000)
`define BORC_TICK_CYCLES    (`BORC_TICK_NS / `BORC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Fixed and default times, as printed
// ----------------------------------------------------------------------
`define BORC_BRK_OP_DFLT_MS  2000
`define BORC_BRK_FAIL_DFLT_MS 100
`define BORC_CLOSE_FIX_MS    200
`define BORC_SEAL_DFLT_MS    40
`define BORC_DWELL_STEP_MS   100

// ----------------------------------------------------------------------
// Derived tick counts
// ----------------------------------------------------------------------
`define BORC_BRK_OP_DFLT_T   16'(`BORC_BRK_OP_DFLT_MS / `BORC_TICK_MS)
`define BORC_BRK_FAIL_DFLT_T 16'(`BORC_BRK_FAIL_DFLT_MS / `BORC_TICK_MS)
`define BORC_CLOSE_FIX_T     16'(`BORC_CLOSE_FIX_MS / `BORC_TICK_MS)
`define BORC_SEAL_DFLT_T     16'(`BORC_SEAL_DFLT_MS / `BORC_TICK_MS)
`define BORC_DWELL_STEP_T    20'(`BORC_DWELL_STEP_MS / `BORC_TICK_MS)

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define BORC_NUM_AUX         5
`define BORC_TMR_W           16
`define BORC_DWELL_W         20
`define BORC_TICK_W          22
`define BORC_OUT_RST         1'b0

`endif

/* File: rtl/borc_pkg.sv */
// Purpose: Types shared by the breaker output relay control
// Assumes: Nothing beyond the params header
// Notes:   Binary state codes are written out
`default_nettype none

package borc_pkg;

	typedef enum logic [1:0]
	{
		BORC_IDLE    = 2'b00,
		BORC_HOLD    = 2'b01,
		BORC_RELEASE = 2'b10,
		BORC_SEAL    = 2'b11
	} borc_rly_st_t;

	typedef enum logic [1:0]
	{
		BORC_SELF_RESET = 2'b00,
		BORC_LATCHED    = 2'b01,
		BORC_PULSED     = 2'b10
	} borc_aux_mode_t;

endpackage

`default_nettype wire

/* File: rtl/borc_timer.sv */
// Purpose: Loadable down counter stepped by the common tick
// Assumes: load and tick are one-cycle pulses of clk_sys
// Notes:   expired is high while the count stands at zero
`include "borc_params.svh"
`default_nettype none

module borc_timer
(
	input  wire logic                    clk_sys,
	input  wire logic                    resetn,
	input  wire logic                    tick,
	input  wire logic                    load,
	input  wire logic [`BORC_TMR_W-1:0]  load_val,
	output logic                         expired
);

	logic [`BORC_TMR_W-1:0] cnt_r;

	// Load wins over a tick in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			cnt_r <= '0;
		else if (load)
			cnt_r <= load_val;
		else if (tick && cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	assign expired = (cnt_r == '0);

endmodule

`default_nettype wire

/* File: rtl/borc_top.sv */
// Purpose: Trip, close, self-test and auxiliary output relay control
// Assumes: All inputs synchronous to clk_sys; settings held static
// Notes:   Delays count a 10 ms tick; TICK_CYCLES shortens it in sim
`include "borc_params.svh"
`default_nettype none

module borc_top
#(
	parameter int TICK_CYCLES = `BORC_TICK_CYCLES
)
(
	input  wire logic                    clk_sys,
	input  wire logic                    resetn,
	input  wire logic                    trip_request,
	input  wire logic                    close_request,
	input  wire logic                    breaker_closed_contact,
	input  wire logic                    breaker_open_contact,
	input  wire logic                    closed_contact_assigned,
	input  wire logic                    open_contact_assigned,
	input  wire logic                    brk_op_delay_en,
	input  wire logic [`BORC_TMR_W-1:0]  brk_op_delay,
	input  wire logic                    brk_fail_en,
	input  wire logic [`BORC_TMR_W-1:0]  brk_fail_delay,
	input  wire logic                    trip_seal_prog,
	input  wire logic [9:0]              trip_release_extension,
	input  wire logic                    close_seal_prog,
	input  wire logic [9:0]              close_release_extension,
	input  wire logic                    selftest_fault,
	input  wire logic [`BORC_NUM_AUX-1:0] aux_request,
	input  wire borc_pkg::borc_aux_mode_t aux_mode [`BORC_NUM_AUX],
	input  wire logic [`BORC_NUM_AUX-1:0] aux_energize_op,
	input  wire logic [15:0]             aux_dwell [`BORC_NUM_AUX],
	input  wire logic                    reset_key,
	input  wire logic                    reset_input,
	input  wire logic                    remote_reset,
	output logic                         trip_out,
	output logic                         close_out,
	output logic                         selftest_alarm_output,
	output logic [`BORC_NUM_AUX-1:0]     aux_out
);

	import borc_pkg::*;

	// ------------------------------------------------------------------
	// Common tick
	// ------------------------------------------------------------------
	localparam logic [`BORC_TICK_W-1:0] TICK_LAST =
		`BORC_TICK_W'(TICK_CYCLES - 1);

	logic [`BORC_TICK_W-1:0] tick_cnt_r;
	logic                    tick_r;

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end
		else if (tick_cnt_r == TICK_LAST)
		begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Breaker state confirmation
	// ------------------------------------------------------------------
	logic no_contact;
	logic [1:0] req;
	logic [1:0] conf;
	logic [1:0] seal_prog;
	logic [9:0] seal_set [2];

	assign no_contact = !closed_contact_assigned && !open_contact_assigned;
	assign req        = {close_request, trip_request};
	assign seal_prog  = {close_seal_prog, trip_seal_prog};
	assign seal_set[0] = trip_release_extension;
	assign seal_set[1] = close_release_extension;

	// Open contact preferred for trip, closed contact for close
	assign conf[0] = open_contact_assigned ? breaker_open_contact
		: !breaker_closed_contact;
	assign conf[1] = closed_contact_assigned ? breaker_closed_contact
		: !breaker_open_contact;

	// ------------------------------------------------------------------
	// Trip (0) and close (1) channels
	// ------------------------------------------------------------------
	borc_rly_st_t st_r   [2];
	borc_rly_st_t st_nxt [2];
	logic [1:0]   req_d_r;
	logic [1:0]   rly_r;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_rly
			logic                   tmr_load;
			logic [`BORC_TMR_W-1:0] tmr_val;
			logic                   tmr_done;
			logic [`BORC_TMR_W-1:0] seal_t;
			logic [`BORC_TMR_W-1:0] rel_t;
			logic                   fixed_close;

			assign fixed_close = (ch == 1) && no_contact;
			assign seal_t = seal_prog[ch]
				? `BORC_TMR_W'(seal_set[ch])
				: `BORC_SEAL_DFLT_T;

			// Timeout once the request has cleared
			always_comb
			begin
				if (no_contact)
					rel_t = brk_fail_en ? brk_fail_delay
						: `BORC_BRK_FAIL_DFLT_T;
				else
					rel_t = brk_op_delay_en ? brk_op_delay
						: `BORC_BRK_OP_DFLT_T;
			end

			always_comb
			begin
				st_nxt[ch] = st_r[ch];
				tmr_load   = 1'b0;
				tmr_val    = rel_t;
				case (st_r[ch])
				BORC_IDLE:
				begin
					// Fixed close pulse needs a fresh request
					if (req[ch] && (!fixed_close || !req_d_r[ch]))
					begin
						st_nxt[ch] = BORC_HOLD;
						tmr_load   = fixed_close;
						tmr_val    = `BORC_CLOSE_FIX_T;
					end
				end
				BORC_HOLD:
				begin
					if (fixed_close ? tmr_done
						: (!req[ch] && !no_contact && conf[ch]))
					begin
						st_nxt[ch] = BORC_SEAL;
						tmr_load   = 1'b1;
						tmr_val    = seal_t;
					end
					else if (!fixed_close && !req[ch])
					begin
						st_nxt[ch] = BORC_RELEASE;
						tmr_load   = 1'b1;
					end
				end
				BORC_RELEASE:
				begin
					if (req[ch])
						st_nxt[ch] = BORC_HOLD;
					else if ((!no_contact && conf[ch]) || tmr_done)
					begin
						st_nxt[ch] = BORC_SEAL;
						tmr_load   = 1'b1;
						tmr_val    = seal_t;
					end
				end
				BORC_SEAL:
				begin
					if (req[ch] && !fixed_close)
						st_nxt[ch] = BORC_HOLD;
					else if (tmr_done)
						st_nxt[ch] = BORC_IDLE;
				end
				default:
					st_nxt[ch] = BORC_IDLE;
				endcase
			end

			always_ff @(posedge clk_sys)
			begin
				if (!resetn)
				begin
					st_r[ch]    <= BORC_IDLE;
					req_d_r[ch] <= 1'b0;
					rly_r[ch]   <= `BORC_OUT_RST;
				end
				else
				begin
					st_r[ch]    <= st_nxt[ch];
					req_d_r[ch] <= req[ch];
					rly_r[ch]   <= (st_nxt[ch] != BORC_IDLE);
				end
			end

			borc_timer u_tmr
			(
				.clk_sys  (clk_sys),
				.resetn   (resetn),
				.tick     (tick_r),
				.load     (tmr_load),
				.load_val (tmr_val),
				.expired  (tmr_done)
			);
		end
	endgenerate

	assign trip_out  = rly_r[0];
	assign close_out = rly_r[1];

	// ------------------------------------------------------------------
	// Self-test alarm
	// ------------------------------------------------------------------
	// Fail-safe: coil energized while healthy, drops on fault or power loss
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			selftest_alarm_output <= `BORC_OUT_RST;
		else
			selftest_alarm_output <= !selftest_fault;
	end

	// ------------------------------------------------------------------
	// Auxiliary outputs
	// ------------------------------------------------------------------
	logic any_reset;

	assign any_reset = reset_key || reset_input || remote_reset;

	genvar ax;
	generate
		for (ax = 0; ax < `BORC_NUM_AUX; ax++)
		begin : g_aux
			logic                    op_r;
			logic                    op_nxt;
			logic                    req_d_r;
			logic                    dwell_run_r;
			logic [`BORC_DWELL_W-1:0] dwell_r;
			logic [15:0]             units;

			// A zero setting is clamped to the smallest step
			assign units = (aux_dwell[ax] == 16'h0000) ? 16'h0001
				: aux_dwell[ax];

			always_comb
			begin
				case (aux_mode[ax])
				BORC_LATCHED:
					op_nxt = aux_request[ax]
						|| (op_r && !any_reset);
				BORC_PULSED:
					op_nxt = dwell_run_r
						|| (aux_request[ax] && !req_d_r);
				default:
					op_nxt = aux_request[ax];
				endcase
			end

			// Dwell counts ticks; only a rising request from rest starts it
			always_ff @(posedge clk_sys)
			begin
				if (!resetn)
				begin
					dwell_run_r <= 1'b0;
					dwell_r     <= '0;
				end
				else if (aux_mode[ax] != BORC_PULSED)
				begin
					dwell_run_r <= 1'b0;
					dwell_r     <= '0;
				end
				else if (!dwell_run_r)
				begin
					if (aux_request[ax] && !req_d_r)
					begin
						dwell_run_r <= 1'b1;
						dwell_r <= `BORC_DWELL_W'(`BORC_DWELL_W'(units)
							* `BORC_DWELL_STEP_T);
					end
				end
				else if (tick_r)
				begin
					if (dwell_r <= `BORC_DWELL_W'(1))
						dwell_run_r <= 1'b0;
					dwell_r <= dwell_r - 1'b1;
				end
			end

			always_ff @(posedge clk_sys)
			begin
				if (!resetn)
				begin
					op_r        <= 1'b0;
					req_d_r     <= 1'b0;
					aux_out[ax] <= `BORC_OUT_RST;
				end
				else
				begin
					op_r        <= op_nxt;
					req_d_r     <= aux_request[ax];
					aux_out[ax] <= aux_energize_op[ax] ? op_nxt
						: !op_nxt;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: test/borc_chk_assertions.sv */
// Purpose: Port assertions for the relay output control
// Assumes: Settings held static while watched
// Notes:   Bound into every borc_top
`default_nettype none
module borc_chk
	import borc_pkg::*;
(
	input wire logic                    clk_sys,
	input wire logic                    resetn,
	input wire logic                    trip_request,
	input wire logic                    close_request,
	input wire logic                    closed_contact_assigned,
	input wire logic                    open_contact_assigned,
	input wire logic                    selftest_fault,
	input wire logic [4:0]              aux_request,
	input wire borc_pkg::borc_aux_mode_t aux_mode [5],
	input wire logic [4:0]              aux_energize_op,
	input wire logic                    reset_key,
	input wire logic                    reset_input,
	input wire logic                    remote_reset,
	input wire logic                    trip_out,
	input wire logic                    close_out,
	input wire logic                    selftest_alarm_output,
	input wire logic [4:0]              aux_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_trip_on;
		trip_request |=> trip_out;
	endproperty
	a_trip_on: assert property (p_trip_on) else $error("trip drop");
	property p_close_on;
		(closed_contact_assigned || open_contact_assigned) && close_request
			|=> close_out;
	endproperty
	a_close_on: assert property (p_close_on) else $error("close drop");
	property p_close_fix;
		$rose(close_out) && !closed_contact_assigned && !open_contact_assigned
			|-> close_out[*8];
	endproperty
	a_close_fix: assert property (p_close_fix) else $error("close short");
	property p_self;
		aux_mode[0] == BORC_SELF_RESET && aux_energize_op[0]
			|=> aux_out[0] == $past(aux_request[0]);
	endproperty
	a_self: assert property (p_self) else $error("self reset");
	property p_pol;
		aux_mode[1] == BORC_SELF_RESET && !aux_energize_op[1]
			|=> aux_out[1] != $past(aux_request[1]);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity");
	property p_latch_set;
		aux_mode[2] == BORC_LATCHED && aux_request[2]
			|=> aux_out[2] == aux_energize_op[2];
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch set");
	// Past reset guards the first edge after release
	property p_latch_keep;
		aux_mode[2] == BORC_LATCHED && aux_out[2] == aux_energize_op[2]
			&& $past(resetn) && !(reset_key || reset_input || remote_reset)
			|=> $stable(aux_out[2]);
	endproperty
	a_latch_keep: assert property (p_latch_keep) else $error("latch");
	property p_alarm;
		1'b1 |=> selftest_alarm_output != $past(selftest_fault);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm");
	property p_pulse;
		$rose(aux_out[3]) && aux_mode[3] == BORC_PULSED && aux_energize_op[3]
			|-> aux_out[3][*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse short");
	c_trip: cover property ($fell(trip_out));
	c_clr: cover property ($fell(aux_out[2]));
	c_pulse: cover property ($fell(aux_out[3]));
endmodule
bind borc_top borc_chk u_chk (.clk_sys, .resetn, .trip_request,
	.close_request, .closed_contact_assigned, .open_contact_assigned,
	.selftest_fault, .aux_request, .aux_mode, .aux_energize_op, .reset_key,
	.reset_input, .remote_reset, .trip_out, .close_out,
	.selftest_alarm_output, .aux_out);
`default_nettype wire

/* File: test/borc_brk_model.sv */
// Purpose: Breaker answering the coil drives with its contacts
// Assumes: Coil drives registered on clk_sys
// Notes:   stuck models a breaker that never moves
`default_nettype none
module borc_brk_model
(
	input  wire logic       clk_sys,
	input  wire logic       trip_out,
	input  wire logic       close_out,
	input  wire logic       stuck,
	input  wire logic [7:0] lag,
	output logic            breaker_closed_contact,
	output logic            breaker_open_contact
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       closed_r = 1'b1;
	logic [7:0] cnt_r = 8'h0;
	wire        drive = closed_r ? trip_out : close_out;
	// Mechanism moves only after lag cycles of coil drive
	always_ff @(posedge clk_sys)
	begin
		if (drive && !stuck && cnt_r >= lag)
		begin
			closed_r <= !closed_r;
			cnt_r    <= 8'h0;
		end
		else
			cnt_r <= drive ? cnt_r + 8'h1 : 8'h0;
	end
	assign breaker_closed_contact = closed_r;
	assign breaker_open_contact = !closed_r;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the relay output control
// Assumes: TICK_CYCLES of 4, breaker model on the contacts
// Notes:   Length windows allow two ticks short and six cycles long
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import borc_pkg::*;
	localparam int TK = 4;
	logic clk_sys = 0, resetn = 0, trip_request = 0, close_request = 0;
	logic ca = 1, oa = 1, brk_op_delay_en = 0, brk_fail_en = 0, stuck = 0;
	logic trip_seal_prog = 0, close_seal_prog = 0, selftest_fault = 0;
	logic reset_key = 0, reset_input = 0, remote_reset = 0;
	logic [15:0] brk_op_delay = 16'h0, brk_fail_delay = 16'h0;
	logic [9:0] trip_release_extension = 10'h0;
	logic [9:0] close_release_extension = 10'h0;
	logic [7:0] lag = 8'h4;
	logic [4:0] aux_request = 5'h0, aux_energize_op = 5'h0d;
	borc_aux_mode_t aux_mode [5] = '{BORC_SELF_RESET, BORC_SELF_RESET,
		BORC_LATCHED, BORC_PULSED, BORC_LATCHED};
	logic [15:0] aux_dwell [5] = '{16'h1, 16'h1, 16'h1, 16'h2, 16'h1};
	logic trip_out, close_out, selftest_alarm_output, bc, bo;
	logic [4:0] aux_out;
	logic [1:0] ex;
	int n_mismatch = 0, total_checks = 0, cyc_cnt = 0;
	wire [2:0] mon = {aux_out[3], close_out, trip_out};
	// An unassigned contact reads open circuit
	wire cc = ca & bc;
	wire oc = oa & bo;
	always #2 clk_sys = ~clk_sys;
	borc_brk_model brk (.clk_sys, .trip_out, .close_out, .stuck, .lag,
		.breaker_closed_contact(bc), .breaker_open_contact(bo));
	borc_top #(.TICK_CYCLES(TK)) dut (.clk_sys, .resetn, .trip_request,
		.close_request, .breaker_closed_contact(cc),
		.breaker_open_contact(oc), .closed_contact_assigned(ca),
		.open_contact_assigned(oa), .brk_op_delay_en, .brk_op_delay,
		.brk_fail_en, .brk_fail_delay, .trip_seal_prog,
		.trip_release_extension, .close_seal_prog, .close_release_extension,
		.selftest_fault, .aux_request, .aux_mode, .aux_energize_op,
		.aux_dwell, .reset_key, .reset_input, .remote_reset, .trip_out,
		.close_out, .selftest_alarm_output, .aux_out);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task cyc(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task chk(string nm, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	// Coil level of an auxiliary for its operated state and polarity
	function logic [1:0] aux_lvl(logic [1:0] op, logic [1:0] en);
		return (op & en) | (~op & ~en);
	endfunction
	function bit ok(int n, int t);
		return n >= (t - 2) * TK && n <= t * TK + 6;
	endfunction
	// Hold a request, drop it, time the output's release in cycles
	task op(int w, int hold, int t);
		int n;
		n = 0;
		trip_request = (w == 0);
		close_request = (w == 1);
		aux_request[3] = (w == 2);
		cyc(hold);
		chk("out_on", mon[w], 1'b1);
		trip_request = 0;
		close_request = 0;
		aux_request[3] = 0;
		while (mon[w] !== 1'b0 && n < 4000)
		begin
			cyc(1);
			n++;
		end
		chk("out_len", ok(n, t), 1'b1);
	endtask
	task end_of_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc_cnt++;
		if (cyc_cnt == 10000)
		begin
			n_mismatch++;
			end_of_test;
		end
	end
	initial
	begin
		void'($urandom(32'h7a6acb0f));
		cyc(12);
		resetn = 1;
		cyc(2);
		for (int k = 0; k < 3; k++)
		begin
			ca = (k != 2);
			oa = (k != 1);
			trip_seal_prog = (k != 0);
			trip_release_extension = 10'($urandom_range(0, 30));
			close_seal_prog = (k != 0);
			close_release_extension = 10'($urandom_range(0, 30));
			lag = 8'($urandom_range(1, 8));
			op(0, 12, k ? trip_release_extension : 4);
			op(1, 12, k ? close_release_extension : 4);
		end
		stuck = 1;
		trip_release_extension = 10'h0;
		trip_request = 1;
		cyc(3);
		trip_request = 0;
		cyc(100);
		chk("trip_wait", trip_out, 1'b1);
		op(0, 3, 200);
		brk_op_delay_en = 1;
		brk_op_delay = 16'($urandom_range(5, 30));
		op(0, 3, brk_op_delay);
		ca = 0;
		oa = 0;
		close_release_extension = 10'h0;
		op(0, 3, 10);
		brk_fail_en = 1;
		brk_fail_delay = 16'h19;
		op(0, 3, 25);
		op(1, 3, 20);
		repeat (40)
		begin
			aux_request[1:0] = 2'($urandom);
			selftest_fault = 1'($urandom);
			cyc(1);
			ex = aux_lvl(aux_request[1:0], aux_energize_op[1:0]);
			chk("aux_rnd", aux_out[1:0], ex);
			chk("alarm", selftest_alarm_output, !selftest_fault);
		end
		aux_request[1:0] = 2'h1;
		cyc(2);
		chk("aux_self", aux_out[1:0], 2'h3);
		for (int r = 0; r < 3; r++)
		begin
			aux_request = aux_request | 5'h14;
			cyc(1);
			aux_request = aux_request & 5'h0b;
			cyc(3);
			chk("latch_set", {aux_out[4], aux_out[2]}, 2'h1);
			{remote_reset, reset_input, reset_key} = 3'h1 << r;
			cyc(1);
			{remote_reset, reset_input, reset_key} = 3'h0;
			cyc(2);
			chk("latch_clr", {aux_out[4], aux_out[2]}, 2'h2);
		end
		// A second request mid-dwell must not restart the pulse
		aux_request[3] = 1;
		cyc(30);
		aux_request[3] = 0;
		cyc(2);
		op(2, 8, 10);
		end_of_test;
	end
endmodule
`default_nettype wire
